// File: verilog/cmpg_gate_control.sv
// Current-mode PWM gate control: oscillator with jitter, pulse latch,
// blanking, soft start and control-unit blanking timers.
// Assumes comparator pins are asynchronous and sense and feedback codes
// come from converters clocked by CLK.
`timescale 1ns/1ps
`default_nettype none
module cmpg_gate_control #(
  parameter int                            SS_STEP_CYC    = cmpg_pkg::SS_STEP_CYC,
  parameter int                            SS_TIME_CYC    = cmpg_pkg::SS_TIME_CYC,
  parameter int                            BLANK_CYC      = cmpg_pkg::BLANK_CYC,
  parameter int                            JIT_PERIOD_CYC = cmpg_pkg::JIT_PERIOD_CYC,
  parameter logic [cmpg_pkg::SENSE_W-1:0]  PEAK_LIMIT     = 10'h300
) (
  input  wire logic                         CLK,
  input  wire logic                         RST,
  input  wire logic                         SUPPLY_ON,
  input  wire logic                         RESTART,
  input  wire logic                         BURST_ACTIVE,
  input  wire logic                         FB_LOW,
  input  wire logic                         FB_HIGH,
  input  wire logic                         BLANK_EXT_DONE,
  input  wire logic                         BURST_CMP,
  input  wire logic [cmpg_pkg::SENSE_W-1:0] SENSE_CODE,
  input  wire logic [cmpg_pkg::CMP_W-1:0]   FEEDBACK_CODE,
  output logic                              GATE,
  output logic                              SINK_ENABLE,
  output logic      [cmpg_pkg::STEP_W-1:0]  SINK_LEVEL,
  output logic                              SOFT_START_DONE,
  output logic                              BURST_REQ,
  output logic                              RESTART_REQ
);

  // Counter widths follow the (possibly shortened) parameters.
  localparam int SS_W   = $clog2(SS_TIME_CYC + 1);
  localparam int STEP_W = $clog2(SS_STEP_CYC + 1);
  localparam int BLK_W  = $clog2(BLANK_CYC + 1);
  localparam int JSTEP  = JIT_PERIOD_CYC / (4 * cmpg_pkg::JIT_SPAN_CYC);
  localparam int JT_W   = $clog2(JSTEP + 1);

  // Refuse timings the sequencer cannot honour.
  if (SS_STEP_CYC < 1 || BLANK_CYC < 1 || JSTEP < 1 ||
      SS_STEP_CYC * (cmpg_pkg::SS_STEPS - 1) > SS_TIME_CYC) begin : g_bad_timing
    $error("cmpg_gate_control: soft start, blanking or jitter timing unusable");
  end

  // Sense gain of 3.3 done as 33/10 in integers; truncation is under one code.
  function automatic logic [cmpg_pkg::CMP_W-1:0] scale_sense(
    input logic [cmpg_pkg::SENSE_W-1:0] s
  );
    int prod;
    prod = int'(s) * cmpg_pkg::GAIN_NUM / cmpg_pkg::GAIN_DEN;
    return cmpg_pkg::CMP_W'(prod);
  endfunction : scale_sense

  // Threshold lowered by slope so the late switch-off lands on the limit.
  function automatic logic [cmpg_pkg::SENSE_W-1:0] dyn_threshold(
    input logic [cmpg_pkg::SENSE_W-1:0] limit,
    input logic [cmpg_pkg::SENSE_W-1:0] slope
  );
    int drop;
    drop = int'(slope) * cmpg_pkg::PDC_GAIN;
    if (drop >= int'(limit)) begin
      return '0;
    end
    return cmpg_pkg::SENSE_W'(int'(limit) - drop);
  endfunction : dyn_threshold

  // Synchronised pin levels.
  logic [cmpg_pkg::SYN_N-1:0] syn;
  logic supply_s;              // Supply above on-threshold.
  logic restart_s;             // Auto restart attempt level.
  logic restart_prev_q;        // Previous restart level for edge detection.
  logic restart_rise;          // One-cycle restart attempt.

  cmpg_sync #(
    .W (cmpg_pkg::SYN_N)
  ) u_sync (
    .clk (CLK),
    .rst (RST),
    .d   ({BURST_CMP, BLANK_EXT_DONE, FB_HIGH, FB_LOW, BURST_ACTIVE, RESTART, SUPPLY_ON}),
    .q   (syn)
  );

  assign supply_s     = syn[cmpg_pkg::SYN_SUPPLY];
  assign restart_s    = syn[cmpg_pkg::SYN_RESTART];
  assign restart_rise = restart_s && !restart_prev_q;

  // Restart edge detector looks only at the second synchroniser stage.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      restart_prev_q <= 1'h0;
    end else begin
      restart_prev_q <= restart_s;
    end
  end

  // Soft start sequencer state.
  cmpg_pkg::cmpg_ss_e          ss_state_q;
  logic [SS_W-1:0]             ss_total_q;   // Cycles since ramp start.
  logic [STEP_W-1:0]           ss_tick_q;    // Cycles within one step.
  logic [cmpg_pkg::STEP_W-1:0] sink_q;       // Sink strength, falls per step.
  logic                        sink_en_q;
  logic                        ss_done_q;

  // Soft start: a supply drop or restart attempt always wins over the ramp.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ss_state_q <= cmpg_pkg::SS_OFF;
      ss_total_q <= '0;
      ss_tick_q  <= '0;
      sink_q     <= cmpg_pkg::SINK_FULL;
      sink_en_q  <= 1'h0;
      ss_done_q  <= 1'h0;
    end else if (!supply_s) begin
      // Below off-threshold the counter returns to zero for the next start.
      ss_state_q <= cmpg_pkg::SS_OFF;
      ss_total_q <= '0;
      ss_tick_q  <= '0;
      sink_q     <= cmpg_pkg::SINK_FULL;
      sink_en_q  <= 1'h0;
      ss_done_q  <= 1'h0;
    end else if (restart_rise || ss_state_q == cmpg_pkg::SS_OFF) begin
      // Fresh ramp at power-up and at every restart attempt.
      ss_state_q <= cmpg_pkg::SS_RAMP;
      ss_total_q <= '0;
      ss_tick_q  <= '0;
      sink_q     <= cmpg_pkg::SINK_FULL;
      sink_en_q  <= 1'h1;
      ss_done_q  <= 1'h0;
    end else if (ss_state_q == cmpg_pkg::SS_RAMP) begin
      if (ss_total_q == SS_W'(SS_TIME_CYC - 1)) begin
        // Ramp over: sink released, duty limited by the feedback, peak and burst trips and the ceiling.
        ss_state_q <= cmpg_pkg::SS_RUN;
        sink_en_q  <= 1'h0;
        ss_done_q  <= 1'h1;
      end else begin
        ss_total_q <= ss_total_q + SS_W'(1);
      end
      if (ss_tick_q == STEP_W'(SS_STEP_CYC - 1)) begin
        ss_tick_q <= '0;
        if (sink_q != '0) begin
          sink_q <= sink_q - cmpg_pkg::STEP_W'(1);
        end
      end else begin
        ss_tick_q <= ss_tick_q + STEP_W'(1);
      end
    end
  end

  // Oscillator phase and jitter offset.
  logic [cmpg_pkg::PHASE_W-1:0] phase_q;
  logic signed [6:0]            jit_q;       // Period offset in cycles.
  logic                         jit_up_q;    // Direction of the triangle.
  logic [JT_W-1:0]              jit_tick_q;
  logic [cmpg_pkg::PHASE_W-1:0] period_m1;   // Last phase of this period.
  logic [cmpg_pkg::PHASE_W-1:0] on_limit;    // First phase past the duty ceiling.

  // Period follows the jitter offset; the duty ceiling scales with it.
  always_comb begin
    int per;
    per       = cmpg_pkg::OSC_PERIOD_CYC + int'(jit_q);
    period_m1 = cmpg_pkg::PHASE_W'(per - 1);
    on_limit  = cmpg_pkg::PHASE_W'(per * cmpg_pkg::DUTY_NUM / cmpg_pkg::DUTY_DEN);
  end

  // Free-running phase counter; phase zero is the set pulse.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase_q <= '0;
    end else if (phase_q >= period_m1) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_q + cmpg_pkg::PHASE_W'(1);
    end
  end

  // Triangle jitter, held at zero outside normal operation.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      jit_q      <= '0;
      jit_up_q   <= 1'h1;
      jit_tick_q <= '0;
    end else if (ss_state_q != cmpg_pkg::SS_RUN) begin
      jit_q      <= '0;
      jit_up_q   <= 1'h1;
      jit_tick_q <= '0;
    end else if (jit_tick_q == JT_W'(JSTEP - 1)) begin
      jit_tick_q <= '0;
      if (jit_up_q) begin
        jit_q    <= jit_q + 7'sd1;
        jit_up_q <= (jit_q + 7'sd1) < 7'(cmpg_pkg::JIT_SPAN_CYC);
      end else begin
        jit_q    <= jit_q - 7'sd1;
        jit_up_q <= (jit_q - 7'sd1) <= -7'(cmpg_pkg::JIT_SPAN_CYC);
      end
    end else begin
      jit_tick_q <= jit_tick_q + JT_W'(1);
    end
  end

  // Pulse latch and on-time counter.
  logic                          gate_q;
  logic [3:0]                    on_cnt_q;   // Saturating cycles since turn-on.
  logic [cmpg_pkg::SENSE_W-1:0]  sense_prev_q;
  logic                          blank;
  logic [cmpg_pkg::SENSE_W-1:0]  sense_eff;
  logic [cmpg_pkg::SENSE_W-1:0]  slope;
  logic [cmpg_pkg::CMP_W-1:0]    ramp;
  logic [cmpg_pkg::CMP_W-1:0]    amp;
  logic [cmpg_pkg::CMP_W-1:0]    ss_level;
  logic fb_trip, ss_trip, peak_trip, burst_trip, max_hit, osc_set, gate_en, trip_any;

  // Comparisons; blanking forces the sense contribution to zero.
  always_comb begin
    blank      = on_cnt_q < 4'(cmpg_pkg::LEB_CYC);
    sense_eff  = blank ? '0 : SENSE_CODE;
    ramp       = gate_q ? cmpg_pkg::CMP_W'(int'(phase_q) * cmpg_pkg::RAMP_INC) : '0;
    amp        = scale_sense(sense_eff) + ramp;
    ss_level   = cmpg_pkg::CMP_W'(int'(~sink_q) * cmpg_pkg::SS_LSB);
    slope      = (SENSE_CODE > sense_prev_q) ? SENSE_CODE - sense_prev_q : '0;
    fb_trip    = amp > FEEDBACK_CODE;
    ss_trip    = (ss_state_q == cmpg_pkg::SS_RAMP) && (amp > ss_level);
    peak_trip  = !blank && (SENSE_CODE > dyn_threshold(PEAK_LIMIT, slope));
    burst_trip = !blank && syn[cmpg_pkg::SYN_BURST] && syn[cmpg_pkg::SYN_BCMP];
    max_hit    = phase_q >= on_limit;
    osc_set    = phase_q == '0;
    gate_en    = ss_state_q != cmpg_pkg::SS_OFF;
    // Compares are held off for the minimum on-time; the ceiling is not.
    trip_any   = ((on_cnt_q >= 4'(cmpg_pkg::MINON_CYC)) &&
                  (fb_trip || ss_trip || peak_trip || burst_trip)) || max_hit;
  end

  // Latch: set by each oscillator pulse, cleared by the first trip.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      gate_q   <= cmpg_pkg::GATE_RST;
      on_cnt_q <= '0;
    end else if (!gate_en) begin
      gate_q   <= 1'h0;
      on_cnt_q <= '0;
    end else if (osc_set) begin
      gate_q   <= 1'h1;
      on_cnt_q <= '0;
    end else begin
      if (gate_q && trip_any) begin
        gate_q <= 1'h0;
      end
      if (on_cnt_q != 4'hF) begin
        on_cnt_q <= on_cnt_q + 4'h1;
      end
    end
  end

  // Previous sense sample for the slope estimate.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sense_prev_q <= '0;
    end else begin
      sense_prev_q <= SENSE_CODE;
    end
  end

  // Control unit blanking timers.
  cmpg_pkg::cmpg_cu_e cu_state_q;
  logic [BLK_W-1:0]   cu_cnt_q;
  logic               burst_req_q;
  logic               restart_req_q;

  // Trigger must persist through the whole wait or the timer restarts.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cu_state_q    <= cmpg_pkg::CU_IDLE;
      cu_cnt_q      <= '0;
      burst_req_q   <= 1'h0;
      restart_req_q <= 1'h0;
    end else begin
      burst_req_q   <= 1'h0;
      restart_req_q <= 1'h0;
      unique case (cu_state_q)
        cmpg_pkg::CU_IDLE: begin
          cu_cnt_q <= '0;
          if (supply_s && syn[cmpg_pkg::SYN_FB_HIGH]) begin
            cu_state_q <= cmpg_pkg::CU_OVL_WAIT;
          end else if (supply_s && syn[cmpg_pkg::SYN_FB_LOW] && !syn[cmpg_pkg::SYN_BURST]) begin
            cu_state_q <= cmpg_pkg::CU_BURST_WAIT;
          end
        end
        cmpg_pkg::CU_BURST_WAIT: begin
          if (!syn[cmpg_pkg::SYN_FB_LOW] || !supply_s) begin
            cu_state_q <= cmpg_pkg::CU_IDLE;
          end else if (cu_cnt_q == BLK_W'(BLANK_CYC - 1)) begin
            burst_req_q <= 1'h1;
            cu_state_q  <= cmpg_pkg::CU_IDLE;
          end else begin
            cu_cnt_q <= cu_cnt_q + BLK_W'(1);
          end
        end
        cmpg_pkg::CU_OVL_WAIT: begin
          if (!syn[cmpg_pkg::SYN_FB_HIGH] || !supply_s) begin
            cu_state_q <= cmpg_pkg::CU_IDLE;
          end else if (cu_cnt_q == BLK_W'(BLANK_CYC - 1)) begin
            cu_state_q <= cmpg_pkg::CU_OVL_EXT;
          end else begin
            cu_cnt_q <= cu_cnt_q + BLK_W'(1);
          end
        end
        cmpg_pkg::CU_OVL_EXT: begin
          // Waits for the external capacitor to charge; no capacitor is instant.
          if (!syn[cmpg_pkg::SYN_FB_HIGH] || !supply_s) begin
            cu_state_q <= cmpg_pkg::CU_IDLE;
          end else if (syn[cmpg_pkg::SYN_EXT]) begin
            restart_req_q <= 1'h1;
            cu_state_q    <= cmpg_pkg::CU_IDLE;
          end
        end
      endcase
    end
  end

  // Outputs straight from flip-flops.
  assign GATE            = gate_q;
  assign SINK_ENABLE     = sink_en_q;
  assign SINK_LEVEL      = sink_q;
  assign SOFT_START_DONE = ss_done_q;
  assign BURST_REQ       = burst_req_q;
  assign RESTART_REQ     = restart_req_q;

  // Checks on the design's own behaviour.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_gate_held_off: assert property (
    ss_state_q == cmpg_pkg::SS_OFF |=> !gate_q)
    else $error("gate on while soft start idle");
  a_duty_ceiling: assert property (
    gate_q && max_hit |=> !gate_q)
    else $error("gate beyond duty ceiling");
  a_min_on_time: assert property (
    gate_q && on_cnt_q < 4'(cmpg_pkg::MINON_CYC) && !max_hit && gate_en
    && supply_s && !restart_rise |=> gate_q)
    else $error("gate off before minimum on-time");
  a_fb_ends_pulse: assert property (
    gate_q && !osc_set && gate_en && on_cnt_q >= 4'(cmpg_pkg::MINON_CYC) && fb_trip
    |=> !gate_q)
    else $error("feedback trip did not end pulse");
  a_peak_ends_pulse: assert property (
    gate_q && !osc_set && gate_en && on_cnt_q >= 4'(cmpg_pkg::MINON_CYC) && peak_trip
    |=> !gate_q)
    else $error("peak trip did not end pulse");
  a_blank_sense: assert property (
    gate_q && on_cnt_q < 4'(cmpg_pkg::LEB_CYC) |-> amp == ramp && !peak_trip)
    else $error("sense seen during blanking");
  a_osc_sets_gate: assert property (
    osc_set && gate_en && supply_s && !restart_rise |=> gate_q && on_cnt_q == 4'h0)
    else $error("oscillator pulse did not set latch");
  a_step_by_one: assert property (
    ss_state_q == cmpg_pkg::SS_RAMP && $changed(sink_q) && supply_s && !$past(restart_rise)
    |-> sink_q == $past(sink_q) - 5'h01)
    else $error("soft start step skipped");
  a_jitter_after_ss: assert property (
    ss_state_q != cmpg_pkg::SS_RUN |=> jit_q == 7'sd0)
    else $error("jitter during soft start");
  a_done_sink_off: assert property (
    ss_done_q |-> !sink_en_q && ss_state_q == cmpg_pkg::SS_RUN)
    else $error("sink still on after soft start");
  a_supply_resets: assert property (
    !supply_s |=> sink_q == cmpg_pkg::SINK_FULL && ss_total_q == '0)
    else $error("soft start not reset on supply loss");

  c_gate_pulse: cover property ($rose(gate_q) ##[1:40] $fell(gate_q));
  c_ss_done:    cover property ($rose(ss_done_q));
  c_burst_req:  cover property (burst_req_q);
  c_restart:    cover property (restart_req_q);

endmodule : cmpg_gate_control
`default_nettype wire

// File: verilog/cmpg_pkg.sv
// Shared constants and types for the current-mode gate control block.
// Assumes a single 40 MHz clock; every time below is turned into cycles of it.
package cmpg_pkg;

  // Clock rate, used to derive every cycle count.
  localparam int CLK_HZ          = 40_000_000;
  localparam int CLK_PER_US      = CLK_HZ / 1_000_000;
  localparam int CLK_PER_MS      = CLK_HZ / 1_000;

  // Oscillator: nominal rate, jitter depth and jitter period.
  localparam int OSC_HZ          = 65_000;
  localparam int OSC_PERIOD_CYC  = CLK_HZ / OSC_HZ;
  localparam int JIT_PCT         = 4;
  localparam int JIT_SPAN_CYC    = OSC_PERIOD_CYC * JIT_PCT / 100;
  localparam int JIT_PERIOD_US   = 4000;
  localparam int JIT_PERIOD_CYC  = CLK_PER_US * JIT_PERIOD_US;

  // Duty ceiling as a fraction of the oscillator period.
  localparam int DUTY_NUM        = 3;
  localparam int DUTY_DEN        = 4;

  // Edge blanking and minimum on-time, both least times rounded up.
  localparam int LEB_NS          = 220;
  localparam int LEB_CYC         = (LEB_NS * CLK_PER_US + 999) / 1000;
  localparam int MINON_NS        = 156;
  localparam int MINON_CYC       = (MINON_NS * CLK_PER_US + 999) / 1000;

  // Soft start: step count, step spacing and total ramp duration.
  localparam int SS_STEPS        = 32;
  localparam int SS_STEP_US      = 600;
  localparam int SS_STEP_CYC     = CLK_PER_US * SS_STEP_US;
  localparam int SS_TIME_MS      = 20;
  localparam int SS_TIME_CYC     = CLK_PER_MS * SS_TIME_MS;

  // Control unit blanking time before burst or auto restart requests.
  localparam int BLANK_MS        = 20;
  localparam int BLANK_CYC       = CLK_PER_MS * BLANK_MS;

  // Datapath widths and scaling of the sense path.
  localparam int SENSE_W         = 10;
  localparam int CMP_W           = 14;
  localparam int PHASE_W         = 10;
  localparam int STEP_W          = 5;
  localparam int GAIN_NUM        = 33;
  localparam int GAIN_DEN        = 10;
  localparam int RAMP_INC        = 8;
  localparam int SS_LSB          = 512;
  localparam int PDC_GAIN        = 2;

  // Reset values.
  localparam logic [STEP_W-1:0] SINK_FULL  = 5'h1F;
  localparam logic              GATE_RST   = 1'h0;

  // Indices of the synchronised single-bit inputs.
  localparam int SYN_SUPPLY      = 0;
  localparam int SYN_RESTART     = 1;
  localparam int SYN_BURST       = 2;
  localparam int SYN_FB_LOW      = 3;
  localparam int SYN_FB_HIGH     = 4;
  localparam int SYN_EXT         = 5;
  localparam int SYN_BCMP        = 6;
  localparam int SYN_N           = 7;

  // Soft start sequencer states.
  typedef enum logic [2:0] {
    SS_OFF  = 3'h1,
    SS_RAMP = 3'h2,
    SS_RUN  = 3'h4
  } cmpg_ss_e;

  // Control unit blanking states.
  typedef enum logic [3:0] {
    CU_IDLE       = 4'h1,
    CU_BURST_WAIT = 4'h2,
    CU_OVL_WAIT   = 4'h4,
    CU_OVL_EXT    = 4'h8
  } cmpg_cu_e;

endpackage : cmpg_pkg

// File: verilog/cmpg_sync.sv
// Two flip-flop synchroniser for a vector of independent single-bit levels.
// Assumes each bit is a slow level from a pin; no bus coherence is promised.
`timescale 1ns/1ps
`default_nettype none
module cmpg_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // First stage, read only by the second stage.
  logic [W-1:0] meta_q;

  // Both stages clear to zero so that every input reads inactive in reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : cmpg_sync
`default_nettype wire

// File: tb/cmpg_switch_model.sv
// Behavioural power switch and shunt: the sense code ramps while the gate is on.
// Assumes the gate is sampled on the rising edge of the block clock.
`timescale 1ns/1ps
`default_nettype none
module cmpg_switch_model (
  input  wire logic       clk,
  input  wire logic       gate,
  input  wire logic [9:0] slope,
  output logic      [9:0] sense
);
  // Current falls to zero with the switch off and clamps at full scale.
  always_ff @(posedge clk) begin
    if (gate !== 1'b1) sense <= 10'h000;
    else if (sense > 10'h3FF - slope) sense <= 10'h3FF;
    else sense <= sense + slope;
  end
endmodule : cmpg_switch_model
`default_nettype wire

// File: tb/current_mode_pwm_gate_control_test.sv
// Self-checking bench for the gate control block with a switch model.
// Assumes short soft start and blanking counts set through parameters.
`timescale 1ns/1ps
`default_nettype none
module current_mode_pwm_gate_control_test;
  typedef struct {logic [13:0] fb; logic [9:0] sl; logic ba, bc; int lo, hi;} cmpg_row_s;
  logic        clk = 1'b0, rst = 1'b1, sup = 1'b0, rs = 1'b0, ba = 1'b0, bc = 1'b0;
  logic        fl = 1'b0, fh = 1'b0, ed = 1'b1, gate, sk_en, sd, breq, rreq;
  logic [9:0]  sense, slope = 10'h000;
  logic [13:0] fb = 14'h3FFF;
  logic [4:0]  sk_lv;
  int          mismatches = 0, checked = 0, cyc = 0, n, h, t0;
  // Pulse widths expected for each drive condition after soft start.
  cmpg_row_s rows[7] = '{
    '{14'h3FFF, 10'h000, 1'b0, 1'b0, 440, 480},
    '{14'h0000, 10'h000, 1'b0, 1'b0, 7, 9},
    '{14'h00C8, 10'h000, 1'b0, 1'b0, 24, 29},
    '{14'h0800, 10'h002, 1'b0, 1'b0, 134, 146},
    '{14'h3FFF, 10'h004, 1'b0, 1'b0, 190, 193},
    '{14'h3FFF, 10'h000, 1'b1, 1'b1, 9, 12},
    '{14'h3FFF, 10'h000, 1'b0, 1'b1, 440, 480}};

  always #12.5 clk = ~clk;

  cmpg_gate_control #(.SS_STEP_CYC(20), .SS_TIME_CYC(1400), .BLANK_CYC(50),
    .JIT_PERIOD_CYC(960)) DUT (.CLK(clk), .RST(rst), .SUPPLY_ON(sup), .RESTART(rs),
    .BURST_ACTIVE(ba), .FB_LOW(fl), .FB_HIGH(fh), .BLANK_EXT_DONE(ed), .BURST_CMP(bc),
    .SENSE_CODE(sense), .FEEDBACK_CODE(fb), .GATE(gate), .SINK_ENABLE(sk_en),
    .SINK_LEVEL(sk_lv), .SOFT_START_DONE(sd), .BURST_REQ(breq), .RESTART_REQ(rreq));

  cmpg_switch_model sw (.clk(clk), .gate(gate), .slope(slope), .sense(sense));

  // Cuts a hang short; the whole run needs well under this many cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Counts edges until the signal shows the wanted level, at most lim.
  task automatic wait_v(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_v

  task automatic ended(string t);
    $display("Test %s finished", t);
  endtask : ended

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    // Supply rises just before phase zero, so the first pulse meets a full sink.
    repeat (609) @(posedge clk);
    #1;
    chk("reset", {gate, sk_en, sk_lv, sd, breq, rreq}, {2'b00, 5'h1F, 3'b000});
    ended("reset");
    @(negedge clk) sup = 1'b1;
    t0 = cyc;
    wait_v(sk_en, 1'b1, 10);
    chk("ramp entry", {n <= 5, sk_lv}, {1'b1, 5'h1F});
    wait_v(gate, 1'b1, 1000);
    wait_v(gate, 1'b0, 100);
    chk("first pulse", n >= 7 && n <= 9, 1);
    wait_v(gate, 1'b1, 1000);
    wait_v(gate, 1'b0, 1000);
    h = n;
    wait_v(gate, 1'b1, 1000);
    chk("ramp period", h + n, 615);
    wait_v(sd, 1'b1, 800);
    chk("ramp end", {sd, sk_en, cyc - t0 >= 1398 && cyc - t0 <= 1404}, 3'b101);
    ended("soft start");
    // Each row is given two pulses to settle through the synchronisers.
    foreach (rows[i]) begin
      @(negedge clk);
      {fb, slope, ba, bc} = {rows[i].fb, rows[i].sl, rows[i].ba, rows[i].bc};
      repeat (2) begin
        wait_v(gate, 1'b0, 1000);
        wait_v(gate, 1'b1, 1000);
      end
      wait_v(gate, 1'b0, 1000);
      h = n;
      chk($sformatf("on time row %0d", i), h >= rows[i].lo && h <= rows[i].hi, 1);
      wait_v(gate, 1'b1, 1000);
      chk($sformatf("period row %0d", i), h + n >= 591 && h + n <= 639, 1);
    end
    @(negedge clk) {fb, slope, ba, bc} = {14'h3FFF, 10'h000, 2'b00};
    ended("pulse rows");
    @(negedge clk) fl = 1'b1;
    wait_v(breq, 1'b1, 80);
    chk("burst wait", n >= 49 && n <= 56, 1);
    @(negedge clk) {fl, ed, fh} = 3'b001;
    wait_v(rreq, 1'b1, 150);
    chk("restart held", rreq, 0);
    @(negedge clk) ed = 1'b1;
    wait_v(rreq, 1'b1, 10);
    chk("restart req", n <= 5, 1);
    @(negedge clk) fh = 1'b0;
    ended("control unit");
    @(negedge clk) rs = 1'b1;
    wait_v(sd, 1'b0, 10);
    chk("rerun", {sd, sk_en, sk_lv}, {2'b01, 5'h1F});
    n = 0;
    while (sk_lv === 5'h1F && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("step", {n >= 17 && n <= 21, sk_lv}, {1'b1, 5'h1E});
    @(negedge clk) rs = 1'b0;
    ended("restart");
    @(negedge clk) sup = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk("supply loss", {gate, sk_en, sd}, 0);
    @(negedge clk) sup = 1'b1;
    wait_v(sk_en, 1'b1, 10);
    chk("ramp from zero", {sk_en, sk_lv}, {1'b1, 5'h1F});
    ended("supply loss");
    tally_and_finish();
  end
endmodule : current_mode_pwm_gate_control_test
`default_nettype wire
